// >>> rff_defines.svh
`ifndef RFF_DEFINES_SVH
`define RFF_DEFINES_SVH

// ----------------------------------------
// frame constants
// ----------------------------------------
`define RFF_DELIM 8'h7e
`define RFF_TYPE_STD 8'h90
`define RFF_TYPE_EXP 8'h91
`define RFF_TYPE_SAMP 8'h92
`define RFF_OPT_SAMP_MASK 8'h03
`define RFF_SAMPLE_SETS 8'h01
`define RFF_UNKNOWN64 64'hffff_ffff_ffff_ffff
`define RFF_CSUM_BASE 8'hff
`define RFF_LEN_BIAS 8'h02
`define RFF_TYPE_POS 8'h03
`define RFF_HDR_LAST_STD 8'h0e
`define RFF_HDR_LAST_EXP 8'h14
`define RFF_HDR_LAST_SAMP 8'h12
`define RFF_DIG_USED 16'h1cff
`define RFF_ANA_USED 8'h8f
`define RFF_ANA_SUPPLY_BIT 7

// ----------------------------------------
// register map
// ----------------------------------------
`define RFF_REG_CTRL 8'h00
`define RFF_REG_STATUS 8'h04
`define RFF_REG_FRAMES 8'h08
`define RFF_REG_DROPS 8'h0c
`define RFF_CTRL_FMT 0
`define RFF_CTRL_API 1
`define RFF_CTRL_RESET 2'h2

// ----------------------------------------
// buffering
// ----------------------------------------
`define RFF_FIFO_DEPTH 32

`endif

// >>> rff_pkg.sv
package rff_pkg;
    typedef enum logic [2:0] {st_idle, st_head, st_tail, st_pay, st_csum} rff_state_t;
    typedef enum logic [1:0] {kind_std, kind_exp, kind_samp} rff_kind_t;
endpackage

// >>> rff_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module rff_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

    fifo_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
        count <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule
`default_nettype wire

// >>> rff_ahb_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "rff_defines.svh"
module rff_ahb_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic busy,
    input wire logic frame_done,
    input wire logic frame_drop,
    output logic fmt_option,
    output logic api_mode
);
    logic take;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [1:0] ctrl;
    logic [31:0] frames;
    logic [31:0] drops;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;
    assign fmt_option = ctrl[`RFF_CTRL_FMT];
    assign api_mode = ctrl[`RFF_CTRL_API];

    // ----------------------------------------
    // address phase capture
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= take && hwrite && (hsize == 3'h2);
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl <= `RFF_CTRL_RESET;
        end else if (wr_pend && wr_addr == `RFF_REG_CTRL) begin
            ctrl <= hwdata[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                `RFF_REG_CTRL: hrdata <= {30'h0, ctrl};
                `RFF_REG_STATUS: hrdata <= {31'h0, busy};
                `RFF_REG_FRAMES: hrdata <= frames;
                `RFF_REG_DROPS: hrdata <= drops;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frames <= 32'h0000_0000;
            drops <= 32'h0000_0000;
        end else begin
            if (frame_done) begin
                frames <= frames + 32'h0000_0001;
            end
            if (frame_drop) begin
                drops <= drops + 32'h0000_0001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rff_framer.sv
`timescale 1ns/100ps
`default_nettype none
`include "rff_defines.svh"
module rff_framer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_is_sample,
    input wire logic [63:0] rx_src64,
    input wire logic rx_src64_known,
    input wire logic [15:0] rx_src16,
    input wire logic [7:0] rx_src_ep,
    input wire logic [7:0] rx_dst_ep,
    input wire logic [15:0] rx_cluster,
    input wire logic [15:0] rx_profile,
    input wire logic [7:0] rx_opts,
    input wire logic [7:0] rx_pay_len,
    input wire logic [15:0] rx_dig_mask,
    input wire logic [7:0] rx_ana_mask,
    input wire logic [15:0] rx_dig_samples,
    input wire logic [79:0] rx_ana_values,
    input wire logic pay_valid,
    output logic pay_ready,
    input wire logic [7:0] pay_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    rff_pkg::rff_state_t state;
    rff_pkg::rff_kind_t kind;
    logic fmt_option;
    logic api_mode;
    logic framed;
    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] fifo_data;
    logic accept;
    logic drop;
    logic adv;
    logic emit;
    logic [7:0] cur;
    logic [7:0] pos;
    logic [7:0] hdr_last;
    logic [3:0] tpos;
    logic [3:0] tail_len;
    logic [7:0] pay_left;
    logic [7:0] sum;
    logic [15:0] len;
    logic [63:0] src64;
    logic [15:0] src16;
    logic [7:0] src_ep;
    logic [7:0] dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic [7:0] opts;
    logic [15:0] dmask;
    logic [7:0] amask;
    logic [7:0] tail [12];
    logic [7:0] next_tail [12];
    logic [3:0] next_tail_len;
    logic [7:0] next_hdr_last;
    logic [15:0] used_dig;
    logic [7:0] used_ana;
    logic frame_done;

    // ----------------------------------------
    // register bus and payload buffer
    // ----------------------------------------
    rff_ahb_regs u_regs (
        .clock(clock),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .busy(state != rff_pkg::st_idle),
        .frame_done(frame_done),
        .frame_drop(drop),
        .fmt_option(fmt_option),
        .api_mode(api_mode)
    );

    rff_fifo #(
        .WIDTH(8),
        .DEPTH(`RFF_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(pay_valid),
        .in_ready(pay_ready),
        .in_data(pay_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // ----------------------------------------
    // request acceptance
    // ----------------------------------------
    assign rx_ready = (state == rff_pkg::st_idle);
    assign accept = rx_valid && rx_ready;
    // samples are only framed, and only with the standard format
    assign drop = accept && rx_is_sample && (fmt_option || !api_mode);
    assign used_dig = rx_dig_mask & `RFF_DIG_USED;
    assign used_ana = rx_ana_mask & `RFF_ANA_USED;
    assign next_hdr_last = rx_is_sample ? `RFF_HDR_LAST_SAMP :
                           (fmt_option ? `RFF_HDR_LAST_EXP : `RFF_HDR_LAST_STD);

    // sample tail: digital word, then analog results from input 0 up
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            next_tail[i] = 8'h00;
        end
        next_tail_len = 4'h0;
        if (used_dig != 16'h0000) begin
            next_tail[0] = rx_dig_samples[15:8] & used_dig[15:8];
            next_tail[1] = rx_dig_samples[7:0] & used_dig[7:0];
            next_tail_len = 4'h2;
        end
        for (int a = 0; a < 5; a++) begin
            if (used_ana[(a == 4) ? `RFF_ANA_SUPPLY_BIT : a]) begin
                next_tail[next_tail_len] = rx_ana_values[16*a+8 +: 8];
                next_tail[4'(next_tail_len + 4'h1)] = rx_ana_values[16*a +: 8];
                next_tail_len = next_tail_len + 4'h2;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            kind <= rff_pkg::kind_std;
            framed <= 1'b1;
            hdr_last <= `RFF_HDR_LAST_STD;
            tail_len <= 4'h0;
            len <= 16'h0000;
            src64 <= 64'h0;
            src16 <= 16'h0000;
            src_ep <= 8'h00;
            dst_ep <= 8'h00;
            cluster <= 16'h0000;
            profile <= 16'h0000;
            opts <= 8'h00;
            dmask <= 16'h0000;
            amask <= 8'h00;
            for (int i = 0; i < 12; i++) begin
                tail[i] <= 8'h00;
            end
        end else if (accept && !drop) begin
            kind <= rx_is_sample ? rff_pkg::kind_samp :
                    (fmt_option ? rff_pkg::kind_exp : rff_pkg::kind_std);
            framed <= api_mode;
            hdr_last <= next_hdr_last;
            tail_len <= rx_is_sample ? next_tail_len : 4'h0;
            len <= 16'(next_hdr_last - `RFF_LEN_BIAS) + 16'(next_tail_len & {4{rx_is_sample}})
                   + 16'(rx_pay_len & {8{!rx_is_sample}});
            src64 <= (fmt_option && !rx_is_sample && !rx_src64_known) ?
                     `RFF_UNKNOWN64 : rx_src64;
            src16 <= rx_src16;
            src_ep <= rx_src_ep;
            dst_ep <= rx_dst_ep;
            cluster <= rx_cluster;
            profile <= rx_profile;
            opts <= rx_is_sample ? (rx_opts & `RFF_OPT_SAMP_MASK) : rx_opts;
            dmask <= used_dig;
            amask <= used_ana;
            tail <= next_tail;
        end
    end

    // ----------------------------------------
    // byte selection
    // ----------------------------------------
    always_comb begin
        cur = 8'h00;
        case (state)
            rff_pkg::st_head: begin
                case (pos)
                    8'h00: cur = `RFF_DELIM;
                    8'h01: cur = len[15:8];
                    8'h02: cur = len[7:0];
                    8'h03: begin
                        case (kind)
                            rff_pkg::kind_exp: cur = `RFF_TYPE_EXP;
                            rff_pkg::kind_samp: cur = `RFF_TYPE_SAMP;
                            default: cur = `RFF_TYPE_STD;
                        endcase
                    end
                    8'h0c: cur = src16[15:8];
                    8'h0d: cur = src16[7:0];
                    8'h0e: cur = (kind == rff_pkg::kind_exp) ? src_ep : opts;
                    8'h0f: cur = (kind == rff_pkg::kind_exp) ? dst_ep : `RFF_SAMPLE_SETS;
                    8'h10: cur = (kind == rff_pkg::kind_exp) ? cluster[15:8] : dmask[15:8];
                    8'h11: cur = (kind == rff_pkg::kind_exp) ? cluster[7:0] : dmask[7:0];
                    8'h12: cur = (kind == rff_pkg::kind_exp) ? profile[15:8] : amask;
                    8'h13: cur = profile[7:0];
                    8'h14: cur = opts;
                    default: cur = src64[8'(8'h0b - pos)*8 +: 8];
                endcase
            end
            rff_pkg::st_tail: cur = tail[tpos];
            rff_pkg::st_pay: cur = fifo_data;
            rff_pkg::st_csum: cur = `RFF_CSUM_BASE - sum;
            default: cur = 8'h00;
        endcase
    end

    assign adv = !out_valid || out_ready;
    assign fifo_ready = (state == rff_pkg::st_pay) && adv;
    assign emit = adv && (state != rff_pkg::st_idle) &&
                  (state != rff_pkg::st_pay || fifo_valid);
    assign frame_done = emit && (state == rff_pkg::st_csum ||
                        (state == rff_pkg::st_pay && !framed && pay_left == 8'h01));

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= rff_pkg::st_idle;
            pos <= 8'h00;
            tpos <= 4'h0;
            pay_left <= 8'h00;
        end else begin
            case (state)
                rff_pkg::st_idle: begin
                    pos <= 8'h00;
                    tpos <= 4'h0;
                    if (accept && !drop) begin
                        pay_left <= rx_is_sample ? 8'h00 : rx_pay_len;
                        if (api_mode) begin
                            state <= rff_pkg::st_head;
                        end else if (rx_pay_len != 8'h00) begin
                            state <= rff_pkg::st_pay;
                        end
                    end
                end
                rff_pkg::st_head: begin
                    if (emit) begin
                        pos <= pos + 8'h01;
                        if (pos == hdr_last) begin
                            if (tail_len != 4'h0) begin
                                state <= rff_pkg::st_tail;
                            end else if (pay_left != 8'h00) begin
                                state <= rff_pkg::st_pay;
                            end else begin
                                state <= rff_pkg::st_csum;
                            end
                        end
                    end
                end
                rff_pkg::st_tail: begin
                    if (emit) begin
                        tpos <= tpos + 4'h1;
                        if (tpos == 4'(tail_len - 4'h1)) begin
                            state <= rff_pkg::st_csum;
                        end
                    end
                end
                rff_pkg::st_pay: begin
                    if (emit) begin
                        pay_left <= pay_left - 8'h01;
                        if (pay_left == 8'h01) begin
                            state <= framed ? rff_pkg::st_csum : rff_pkg::st_idle;
                        end
                    end
                end
                rff_pkg::st_csum: begin
                    if (emit) begin
                        state <= rff_pkg::st_idle;
                    end
                end
                default: state <= rff_pkg::st_idle;
            endcase
        end
    end

    // running sum from the type byte through the last data byte
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sum <= 8'h00;
        end else if (state == rff_pkg::st_idle) begin
            sum <= 8'h00;
        end else if (emit && state != rff_pkg::st_csum &&
                     (state != rff_pkg::st_head || pos >= `RFF_TYPE_POS)) begin
            sum <= sum + cur;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= 8'h00;
        end else if (adv) begin
            out_valid <= emit;
            if (emit) begin
                out_data <= cur;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    delim_first_a: assert property (@(posedge clock) disable iff (!rst_n)
        emit && state == rff_pkg::st_head && pos == 8'h00 |=> out_data == `RFF_DELIM)
        else $error("frame did not open with delimiter");
    type_std_a: assert property (@(posedge clock) disable iff (!rst_n)
        emit && state == rff_pkg::st_head && pos == 8'h03 && kind == rff_pkg::kind_std
        |=> out_data == `RFF_TYPE_STD) else $error("standard type byte wrong");
    type_exp_a: assert property (@(posedge clock) disable iff (!rst_n)
        accept && !rx_is_sample && fmt_option && api_mode
        |=> kind == rff_pkg::kind_exp && hdr_last == `RFF_HDR_LAST_EXP)
        else $error("explicit format not chosen");
    type_samp_a: assert property (@(posedge clock) disable iff (!rst_n)
        emit && state == rff_pkg::st_head && pos == 8'h03 && kind == rff_pkg::kind_samp
        |=> out_data == `RFF_TYPE_SAMP) else $error("sample type byte wrong");
    sample_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
        accept && rx_is_sample && !api_mode && !out_valid
        |=> (state == rff_pkg::st_idle && !out_valid) ##1 !out_valid)
        else $error("sample framed in transparent mode");
    samp_opts_a: assert property (@(posedge clock) disable iff (!rst_n)
        emit && state == rff_pkg::st_head && pos == 8'h0e && kind == rff_pkg::kind_samp
        |=> (out_data & ~`RFF_OPT_SAMP_MASK) == 8'h00) else $error("sample options stray bits");
    samp_sets_a: assert property (@(posedge clock) disable iff (!rst_n)
        emit && state == rff_pkg::st_head && pos == 8'h0f && kind == rff_pkg::kind_samp
        |=> out_data == `RFF_SAMPLE_SETS) else $error("sample set count not one");
    no_tail_a: assert property (@(posedge clock) disable iff (!rst_n)
        accept && !drop && rx_is_sample && used_dig == 16'h0000 && used_ana == 8'h00
        |=> tail_len == 4'h0) else $error("samples emitted with empty masks");
    unknown_src_a: assert property (@(posedge clock) disable iff (!rst_n)
        accept && !drop && fmt_option && !rx_is_sample && !rx_src64_known
        |=> src64 == `RFF_UNKNOWN64) else $error("unknown source not all ones");
    csum_value_a: assert property (@(posedge clock) disable iff (!rst_n)
        emit && state == rff_pkg::st_csum |=> out_data == 8'(`RFF_CSUM_BASE - $past(sum)))
        else $error("checksum byte wrong");
endmodule
`default_nettype wire

// >>> rff_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// host side: takes framed bytes, stalls on request, checks checksums
// ----------------------------------------
module rff_host_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [7:0] out_data,
    output logic csum_bad
);
    logic [15:0] idx;
    logic [15:0] len;
    logic [7:0] sum;
    always_ff @(posedge clock) begin
        out_ready <= rst_n && !stall;
    end
    // length is taken msb first, sum runs from the type byte on
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            idx <= 0;
            len <= 0;
            sum <= 0;
            csum_bad <= 0;
        end else if (out_valid && out_ready) begin
            idx <= (idx == len + 3) ? 16'h0 : idx + 1;
            if (idx == 1) len[15:8] <= out_data;
            if (idx == 2) len[7:0] <= out_data;
            sum <= (idx < 3) ? 8'h0 : sum + out_data;
            if (idx == len + 3 && sum + out_data != 8'hff) csum_bad <= 1;
        end
    end
endmodule
`default_nettype wire

// >>> rff_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rff_framer_tb;
    typedef struct packed {
        logic fmt, known, samp;
        logic [7:0] plen;
        logic [15:0] dig;
        logic [7:0] ana, typ;
    } rff_row_t;
    logic clock = 0, rst_n = 0, hsel = 1, hwrite = 0, stall = 0, rx_valid = 0, pay_valid = 0;
    logic rx_is_sample = 0, rx_src64_known = 1;
    logic [31:0] haddr = 0, hwdata = 0, d, errors = 0, checked = 0, cyc = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire hready, hreadyout, hresp, rx_ready, pay_ready, out_valid, out_ready, csum_bad;
    wire [31:0] hrdata;
    wire [7:0] out_data;
    logic [63:0] rx_src64 = 64'h0011_2233_4455_6677;
    logic [15:0] rx_src16 = 16'h7d84, rx_cluster = 16'h2211, rx_profile = 16'hc105;
    logic [7:0] rx_src_ep = 8'he0, rx_dst_ep = 8'he1, rx_opts = 8'hff, rx_pay_len = 0;
    logic [7:0] pay_data = 0, rx_ana_mask = 0;
    logic [15:0] rx_dig_mask = 0, rx_dig_samples = 16'hffff;
    logic [79:0] rx_ana_values = 80'h0a04_0b03_0c02_0d01_0e00;
    logic [7:0] e[$];
    rff_row_t rows[7] = '{
        '{1'b0, 1'b1, 1'b0, 8'd6, 16'h0, 8'h0, 8'h90},
        '{1'b1, 1'b1, 1'b0, 8'd6, 16'h0, 8'h0, 8'h91},
        '{1'b1, 1'b0, 1'b0, 8'd32, 16'h0, 8'h0, 8'h91},
        '{1'b0, 1'b1, 1'b1, 8'd0, 16'h001c, 8'h02, 8'h92},
        '{1'b0, 1'b1, 1'b1, 8'd0, 16'hffff, 8'hff, 8'h92},
        '{1'b0, 1'b1, 1'b1, 8'd0, 16'h0, 8'h0, 8'h92},
        '{1'b0, 1'b1, 1'b1, 8'd0, 16'h0400, 8'h80, 8'h92}};
    assign hready = hreadyout;
    rff_framer uut (.*);
    rff_host_model host (.*);
    initial begin
        forever #5 clock = ~clock;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            errors++;
            $display("wrong value at %0t ns: got %h want %h", $time, g, x);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (!hready);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (!hready);
        d = hrdata;
    endtask
    task automatic put(input logic [7:0] b);
        e.push_back(b);
    endtask
    task automatic build(input rff_row_t r);
        logic [7:0] s;
        logic [15:0] n;
        e = {r.typ};
        for (int i = 7; i >= 0; i--) put((r.typ == 8'h91 && !r.known) ? 8'hff : rx_src64[8*i+:8]);
        put(rx_src16[15:8]);
        put(rx_src16[7:0]);
        if (r.typ == 8'h91) begin
            put(rx_src_ep);
            put(rx_dst_ep);
            put(rx_cluster[15:8]);
            put(rx_cluster[7:0]);
            put(rx_profile[15:8]);
            put(rx_profile[7:0]);
        end
        if (r.samp) begin
            put(rx_opts & 8'h03);
            put(8'h01);
            put(r.dig[15:8] & 8'h1c);
            put(r.dig[7:0]);
            put(r.ana & 8'h8f);
            if ((r.dig & 16'h1cff) != 0) begin
                put(rx_dig_samples[15:8] & r.dig[15:8] & 8'h1c);
                put(rx_dig_samples[7:0] & r.dig[7:0]);
            end
            for (int i = 0; i < 5; i++) begin
                if (r.ana[(i == 4) ? 7 : i]) begin
                    put(rx_ana_values[16*i+8+:8]);
                    put(rx_ana_values[16*i+:8]);
                end
            end
        end else begin
            put(rx_opts);
            for (int i = 0; i < r.plen; i++) put(8'h40 + i[7:0]);
        end
        n = e.size();
        s = 0;
        foreach (e[i]) s += e[i];
        put(8'hff - s);
        e.push_front(n[7:0]);
        e.push_front(n[15:8]);
        e.push_front(8'h7e);
    endtask
    task automatic request;
        rx_valid <= 1;
        do @(posedge clock); while (!rx_ready);
        rx_valid <= 0;
    endtask
    task automatic run(input rff_row_t r, input int k);
        int seen;
        ahb(1, 32'h0, {30'h0, 1'b1, r.fmt});
        rx_is_sample <= r.samp;
        rx_src64_known <= r.known;
        rx_pay_len <= r.plen;
        rx_dig_mask <= r.dig;
        rx_ana_mask <= r.ana;
        stall <= 1;
        for (int i = 0; i < r.plen; i++) begin
            pay_data <= 8'h40 + i[7:0];
            pay_valid <= 1;
            do @(posedge clock); while (!pay_ready);
        end
        pay_valid <= 0;
        if (r.plen == 32) begin
            @(posedge clock);
            check(pay_ready, 0);
        end
        request();
        build(r);
        seen = 0;
        while (seen < e.size()) begin
            stall <= k[0] & ~stall;
            @(posedge clock);
            if (out_valid && out_ready) begin
                check(out_data, e[seen]);
                seen++;
            end
        end
        stall <= 0;
    endtask
    task automatic drop(input logic [31:0] ctrl, input logic [31:0] n);
        ahb(1, 32'h0, ctrl);
        rx_is_sample <= 1;
        request();
        repeat (30) begin
            @(posedge clock);
            check(out_valid, 0);
        end
        ahb(0, 32'hc, 0);
        check(d, n);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        ahb(0, 32'h0, 0);
        check(d, 2);
        check({hresp, hreadyout}, 32'h1);
        ahb(0, 32'h10, 0);
        check(d, 0);
        foreach (rows[k]) run(rows[k], k);
        ahb(0, 32'h8, 0);
        check(d, 7);
        check(csum_bad, 0);
        // transparent mode: data packet payload leaves raw, no framing
        ahb(1, 32'h0, 0);
        rx_is_sample <= 0;
        rx_pay_len <= 3;
        for (int i = 0; i < 3; i++) begin
            pay_data <= 8'h50 + i[7:0];
            pay_valid <= 1;
            do @(posedge clock); while (!pay_ready);
        end
        pay_valid <= 0;
        request();
        d = 0;
        while (d < 3) begin
            @(posedge clock);
            if (out_valid && out_ready) begin
                check(out_data, 32'h50 + d);
                d++;
            end
        end
        drop(0, 1);
        drop(3, 2);
        // reset in the middle of a frame
        rx_is_sample <= 0;
        stall <= 1;
        request();
        rst_n <= 0;
        repeat (2) @(posedge clock);
        check({out_valid, rx_ready}, 32'h1);
        rst_n <= 1;
        @(posedge clock);
        ahb(0, 32'h8, 0);
        check(d, 0);
        ahb(0, 32'h0, 0);
        check(d, 2);
        final_report;
    end
endmodule
`default_nettype wire
